// ---- logic/dtl_pkg.sv ----
// package: register map, limits and carriers for the delay timer and level compare block
package dtl_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned NTMR = 3;
  localparam int unsigned NEVT = 4;
  localparam int unsigned FLOW_W = 16;
  localparam int unsigned CONV_W = 28;
  localparam int unsigned LVL_W = 11;
  localparam int unsigned TEMP_W = 12;
  localparam int unsigned SEC_W = 16;
  localparam int unsigned VOL_W = 32;
  localparam int unsigned HM_W = 11;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_FLOW = 8'h04;
  localparam logic [AW-1:0] A_RTD = 8'h08;
  localparam logic [AW-1:0] A_STAT = 8'h0c;
  localparam logic [AW-1:0] A_TOD = 8'h10;
  localparam logic [AW-1:0] A_VOL = 8'h14;
  localparam logic [AW-1:0] A_FDISP = 8'h18;
  localparam logic [AW-1:0] A_TMR0 = 8'h20;
  localparam logic [AW-1:0] TMR_STRIDE = 8'h08;
  localparam logic [AW-1:0] TAB_OFS = 8'h04;
  localparam logic [AW-1:0] A_TEL0 = 8'h38;
  localparam logic [AW-1:0] A_EVT0 = 8'h48;
  localparam logic [AW-1:0] WORD_STRIDE = 8'h04;
  localparam int unsigned CTRL_UNIT_LSB = 0;
  localparam int unsigned CTRL_CUSTOM_BIT = 2;
  localparam int unsigned CTRL_CLEAR_BIT = 3;
  localparam int unsigned HI_LSB = 0;
  localparam int unsigned LO_LSB = 16;
  localparam logic [LVL_W-1:0] LEVEL_MAX = 11'd2000;
  localparam logic [LVL_W-1:0] RTD_MAX = 11'd2000;
  localparam logic [LVL_W-1:0] HIFLOW_DEF = 11'd2000;
  localparam logic [LVL_W-1:0] LOFLOW_DEF = 11'd50;
  localparam logic [LVL_W-1:0] RTDH_DEF = 11'd1000;
  localparam logic [LVL_W-1:0] RTDL_DEF = 11'd500;
  localparam logic [16:0] SEC_PER_MIN = 17'd60;
  localparam logic [16:0] SEC_PER_HR = 17'd3600;
  localparam logic [SEC_W-1:0] INTERVAL_MAX = 16'hffff;
  localparam logic [4:0] HR_MAX = 5'd23;
  localparam logic [5:0] MIN_MAX = 6'd59;
  localparam logic [5:0] SEC_MAX = 6'd59;
  localparam logic [2:0] DAY_MAX = 3'd6;
  localparam logic [7:0] EN_TAB_DEF = 8'h40;
  localparam logic [7:0] RST_TAB_DEF = 8'haa;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;

  typedef enum logic [1:0] {DELAY_ON, DELAY_ON_INIT, DELAY_OFF} dtl_mode_e;
  typedef enum logic [1:0] {UNIT_LPS, UNIT_LPM, UNIT_LPH} dtl_unit_e;

  typedef struct packed {
    logic [12:0] rsv;
    dtl_mode_e mode;
    logic [4:0] hr;
    logic [5:0] mi;
    logic [5:0] se;
  } dtl_tcfg_s;

  typedef struct packed {
    logic [15:0] rsv;
    logic [7:0] rst_tab;
    logic [7:0] en_tab;
  } dtl_ttab_s;

  typedef struct packed {
    logic [2:0] rsv;
    logic [6:0] days;
    logic [4:0] off_h;
    logic [5:0] off_m;
    logic [4:0] on_h;
    logic [5:0] on_m;
  } dtl_evt_s;

  typedef struct packed {
    logic [11:0] rsv;
    logic [2:0] day;
    logic [4:0] hr;
    logic [5:0] mi;
    logic [5:0] se;
  } dtl_tod_s;

  typedef struct packed {
    logic logic_input_one;
    logic logic_input_two;
    logic logic_input_three;
  } dtl_tin_s;

  typedef struct packed {
    logic schedule;
    logic rtd_one_low_flag;
    logic rtd_one_high_flag;
    logic low_flow_flag;
    logic high_flow_flag;
    logic [2:0] timer_out;
  } dtl_src_s;

  localparam dtl_tcfg_s TCFG_DEF = '{rsv: '0, mode: DELAY_ON, hr: '0, mi: '0, se: 6'd1};
  localparam dtl_ttab_s TTAB_DEF = '{rsv: '0, rst_tab: RST_TAB_DEF, en_tab: EN_TAB_DEF};
endpackage : dtl_pkg

// ---- logic/dtl_timer_compare.sv ----
// module: three delay timers, flow and rtd level compares, volume total and day schedule
`timescale 1ns/1ns

module dtl_timer_compare
  import dtl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DW-1:0] rdata_out,
  input wire logic [FLOW_W-1:0] flow_lps_in,
  input wire logic [TEMP_W-1:0] rtd_temp_in,
  input wire logic litre_pulse_in,
  input wire dtl_tin_s [NTMR-1:0] timer_in_in,
  output dtl_src_s sources_out
);

  function automatic logic [LVL_W-1:0] clamp_lvl(input logic [15:0] v, input logic [LVL_W-1:0] mx);
    return (v > 16'(mx)) ? mx : v[LVL_W-1:0];
  endfunction : clamp_lvl

  function automatic logic [SEC_W-1:0] hms_sec(input dtl_tcfg_s c);
    logic [16:0] t;
    t = 17'(c.hr) * SEC_PER_HR + 17'(c.mi) * SEC_PER_MIN + 17'(c.se);
    return (t > 17'(INTERVAL_MAX)) ? INTERVAL_MAX : t[SEC_W-1:0];
  endfunction : hms_sec

  function automatic dtl_evt_s clamp_evt(input logic [DW-1:0] w);
    dtl_evt_s e;
    e = dtl_evt_s'(w);
    e.rsv = '0;
    if (e.on_h > HR_MAX) begin
      e.on_h = HR_MAX;
    end
    if (e.off_h > HR_MAX) begin
      e.off_h = HR_MAX;
    end
    if (e.on_m > MIN_MAX) begin
      e.on_m = MIN_MAX;
    end
    if (e.off_m > MIN_MAX) begin
      e.off_m = MIN_MAX;
    end
    return e;
  endfunction : clamp_evt

  dtl_unit_e unit_q;
  logic custom_q;
  logic [LVL_W-1:0] hflow_q;
  logic [LVL_W-1:0] lflow_q;
  logic [LVL_W-1:0] rtdh_q;
  logic [LVL_W-1:0] rtdl_q;
  dtl_tcfg_s tcfg_q [NTMR];
  dtl_ttab_s ttab_q [NTMR];
  dtl_evt_s evt_q [NEVT];
  dtl_tod_s tod_q;
  logic [VOL_W-1:0] vol_q;
  logic [31:0] presc_q;
  logic tick_q;
  logic [CONV_W-1:0] flow_disp;
  logic [SEC_W-1:0] el_q [NTMR];
  logic [NTMR-1:0] tout_q;
  logic [NEVT-1:0] evt_act;
  dtl_src_s src_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rmux;
  logic clear_req;

  // a write with the clear bit low is the declined answer and leaves the total alone
  assign clear_req = wr_in && (addr_in == A_CTRL) && wdata_in[CTRL_CLEAR_BIT];

  // control and level registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      unit_q <= UNIT_LPS;
      custom_q <= 1'b0;
      hflow_q <= HIFLOW_DEF;
      lflow_q <= LOFLOW_DEF;
      rtdh_q <= RTDH_DEF;
      rtdl_q <= RTDL_DEF;
    end else if (ce_in && wr_in) begin
      if (addr_in == A_CTRL) begin
        unit_q <= dtl_unit_e'(wdata_in[CTRL_UNIT_LSB +: 2]);
        custom_q <= wdata_in[CTRL_CUSTOM_BIT];
      end
      if (addr_in == A_FLOW) begin
        hflow_q <= clamp_lvl(wdata_in[HI_LSB +: 16], LEVEL_MAX);
        lflow_q <= clamp_lvl(wdata_in[LO_LSB +: 16], LEVEL_MAX);
      end
      if (addr_in == A_RTD) begin
        rtdh_q <= clamp_lvl(wdata_in[HI_LSB +: 16], RTD_MAX);
        rtdl_q <= clamp_lvl(wdata_in[LO_LSB +: 16], RTD_MAX);
      end
    end
  end

  // timer and event configuration
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NTMR; i++) begin
        tcfg_q[i] <= TCFG_DEF;
        ttab_q[i] <= TTAB_DEF;
      end
      for (int e = 0; e < NEVT; e++) begin
        evt_q[e] <= '0;
      end
    end else if (ce_in && wr_in) begin
      for (int i = 0; i < NTMR; i++) begin
        if (addr_in == AW'(A_TMR0 + TMR_STRIDE * i)) begin
          tcfg_q[i] <= dtl_tcfg_s'(wdata_in & {{13{1'b0}}, {19{1'b1}}});
        end
        if (addr_in == AW'(A_TMR0 + TMR_STRIDE * i + TAB_OFS)) begin
          ttab_q[i] <= dtl_ttab_s'({16'h0000, wdata_in[15:0]});
        end
      end
      for (int e = 0; e < NEVT; e++) begin
        if (addr_in == AW'(A_EVT0 + WORD_STRIDE * e)) begin
          evt_q[e] <= clamp_evt(wdata_in);
        end
      end
    end
  end

  // one-second tick; a long prescale, so simulations shrink TICK_CYCLES
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      presc_q <= '0;
      tick_q <= 1'b0;
    end else if (ce_in) begin
      if (presc_q >= 32'(TICK_CYCLES - 1)) begin
        presc_q <= '0;
        tick_q <= 1'b1;
      end else begin
        presc_q <= presc_q + 32'd1;
        tick_q <= 1'b0;
      end
    end
  end

  // time of day keeping; a software write wins over the tick
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      tod_q <= '0;
    end else if (ce_in) begin
      if (wr_in && addr_in == A_TOD) begin
        tod_q <= dtl_tod_s'({12'h000, wdata_in[19:0]});
      end else if (tick_q) begin
        if (tod_q.se < SEC_MAX) begin
          tod_q.se <= tod_q.se + 6'd1;
        end else begin
          tod_q.se <= '0;
          if (tod_q.mi < MIN_MAX) begin
            tod_q.mi <= tod_q.mi + 6'd1;
          end else begin
            tod_q.mi <= '0;
            if (tod_q.hr < HR_MAX) begin
              tod_q.hr <= tod_q.hr + 5'd1;
            end else begin
              tod_q.hr <= '0;
              tod_q.day <= (tod_q.day < DAY_MAX) ? tod_q.day + 3'd1 : 3'd0;
            end
          end
        end
      end
    end
  end

  // delivered volume: a pulse in the clear cycle still counts
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      vol_q <= '0;
    end else if (ce_in) begin
      if (clear_req) begin
        vol_q <= litre_pulse_in ? 32'd1 : 32'd0;
      end else if (litre_pulse_in) begin
        vol_q <= vol_q + 32'd1;
      end
    end
  end

  // flow in the selected unit, shared by display and compares
  always_comb begin
    case (unit_q)
      UNIT_LPS: flow_disp = CONV_W'(flow_lps_in);
      UNIT_LPM: flow_disp = CONV_W'(flow_lps_in) * CONV_W'(SEC_PER_MIN);
      UNIT_LPH: flow_disp = CONV_W'(flow_lps_in) * CONV_W'(SEC_PER_HR);
      default: flow_disp = CONV_W'(flow_lps_in);
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < NTMR; gi++) begin : g_tmr
      logic [2:0] term;
      logic en_c;
      logic rst_c;
      logic en_prev_q;
      logic armed_q;
      logic init_q;
      logic out_d;
      logic [SEC_W-1:0] ivl;

      assign ivl = hms_sec(tcfg_q[gi]);
      assign term = {timer_in_in[gi].logic_input_one, timer_in_in[gi].logic_input_two,
                     timer_in_in[gi].logic_input_three};
      assign en_c = custom_q ? ttab_q[gi].en_tab[term] : EN_TAB_DEF[term];
      assign rst_c = custom_q ? ttab_q[gi].rst_tab[term] : RST_TAB_DEF[term];

      always_comb begin
        out_d = 1'b0;
        if (rst_c) begin
          out_d = 1'b0;
        end else begin
          case (tcfg_q[gi].mode)
            DELAY_ON, DELAY_ON_INIT: out_d = en_c && armed_q && (el_q[gi] >= ivl);
            // en_prev keeps the output up in the falling cycle before timing is armed
            DELAY_OFF: out_d = en_c || en_prev_q || (armed_q && (el_q[gi] < ivl));
            default: out_d = 1'b0;
          endcase
        end
      end

      // preload waits until the init mode is chosen, as long as no enable edge or reset term has come since reset
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          en_prev_q <= 1'b0;
          armed_q <= 1'b0;
          init_q <= 1'b1;
          el_q[gi] <= '0;
          tout_q[gi] <= 1'b0;
        end else if (ce_in) begin
          en_prev_q <= en_c;
          tout_q[gi] <= out_d;
          if (rst_c) begin
            armed_q <= 1'b0;
            el_q[gi] <= '0;
            init_q <= 1'b0;
          end else if (init_q && tcfg_q[gi].mode == DELAY_ON_INIT) begin
            el_q[gi] <= ivl;
            armed_q <= 1'b1;
            init_q <= 1'b0;
          end else begin
            case (tcfg_q[gi].mode)
              DELAY_ON, DELAY_ON_INIT: begin
                if (en_c && !en_prev_q) begin
                  el_q[gi] <= '0;
                  armed_q <= 1'b1;
                  init_q <= 1'b0;
                end else if (!en_c) begin
                  armed_q <= 1'b0;
                end else if (tick_q && armed_q && el_q[gi] < ivl) begin
                  el_q[gi] <= el_q[gi] + 16'd1;
                end
              end
              DELAY_OFF: begin
                if (!en_c && en_prev_q) begin
                  el_q[gi] <= '0;
                  armed_q <= 1'b1;
                  init_q <= 1'b0;
                end else if (en_c) begin
                  armed_q <= 1'b0;
                end else if (tick_q && armed_q && el_q[gi] < ivl) begin
                  el_q[gi] <= el_q[gi] + 16'd1;
                end
              end
              default: begin
                armed_q <= 1'b0;
                el_q[gi] <= '0;
              end
            endcase
          end
        end
      end
    end
  endgenerate

  genvar ge;
  generate
    for (ge = 0; ge < NEVT; ge++) begin : g_evt
      logic [HM_W-1:0] now_hm;
      logic [HM_W-1:0] on_hm;
      logic [HM_W-1:0] off_hm;
      logic in_win;

      assign now_hm = {tod_q.hr, tod_q.mi};
      assign on_hm = {evt_q[ge].on_h, evt_q[ge].on_m};
      assign off_hm = {evt_q[ge].off_h, evt_q[ge].off_m};
      // an on time later than the off time spans midnight
      assign in_win = (on_hm <= off_hm) ? (now_hm >= on_hm && now_hm < off_hm)
                                        : (now_hm >= on_hm || now_hm < off_hm);
      assign evt_act[ge] = (tod_q.day <= DAY_MAX) && evt_q[ge].days[tod_q.day] && in_win;
    end
  endgenerate

  // compares and digital sources, evaluated every cycle the clock enable is high
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      src_q <= '0;
    end else if (ce_in) begin
      src_q.high_flow_flag <= flow_disp > CONV_W'(hflow_q);
      src_q.low_flow_flag <= flow_disp < CONV_W'(lflow_q);
      src_q.rtd_one_high_flag <= rtd_temp_in > TEMP_W'(rtdh_q);
      src_q.rtd_one_low_flag <= rtd_temp_in < TEMP_W'(rtdl_q);
      src_q.schedule <= |evt_act;
      src_q.timer_out <= tout_q;
    end
  end

  assign sources_out = src_q;

  // read mux; unmapped addresses read as zero
  always_comb begin
    rmux = '0;
    case (addr_in)
      A_CTRL: rmux = DW'({custom_q, unit_q});
      A_FLOW: rmux = DW'({5'h00, lflow_q, 5'h00, hflow_q});
      A_RTD: rmux = DW'({5'h00, rtdl_q, 5'h00, rtdh_q});
      A_STAT: rmux = DW'(src_q);
      A_TOD: rmux = DW'(tod_q);
      A_VOL: rmux = vol_q;
      A_FDISP: rmux = DW'(flow_disp);
      default: rmux = '0;
    endcase
    for (int i = 0; i < NTMR; i++) begin
      if (addr_in == AW'(A_TMR0 + TMR_STRIDE * i)) begin
        rmux = DW'(tcfg_q[i]);
      end
      if (addr_in == AW'(A_TMR0 + TMR_STRIDE * i + TAB_OFS)) begin
        rmux = DW'(ttab_q[i]);
      end
      if (addr_in == AW'(A_TEL0 + WORD_STRIDE * i)) begin
        rmux = DW'(el_q[i]);
      end
    end
    for (int e = 0; e < NEVT; e++) begin
      if (addr_in == AW'(A_EVT0 + WORD_STRIDE * e)) begin
        rmux = DW'(evt_q[e]);
      end
    end
  end

  // read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= '0;
    end else if (ce_in) begin
      rdata_q <= rd_in ? rmux : '0;
    end
  end

  assign rdata_out = rdata_q;

endmodule : dtl_timer_compare

// ---- test/dtl_timer_compare_sva.sv ----
// checker: port-level assertions for the timer and level compare block
`timescale 1ns/1ns
module dtl_chk
  import dtl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DW-1:0] rdata_out,
  input wire logic [FLOW_W-1:0] flow_lps_in,
  input wire logic [TEMP_W-1:0] rtd_temp_in,
  input wire logic litre_pulse_in,
  input wire dtl_tin_s [NTMR-1:0] timer_in_in,
  input wire dtl_src_s sources_out
);
  // shadow copies of the levels, so flag checks track software writes
  logic [1:0] unit_q;
  logic cust_q;
  logic [LVL_W-1:0] fhi_q, flo_q, thi_q, tlo_q;
  logic [CONV_W-1:0] conv;
  logic en0;
  // the level fields are 16 bits wide on the bus; anything above the maximum clamps
  function automatic logic [LVL_W-1:0] clip(input logic [15:0] v);
    return (v > 16'(LEVEL_MAX)) ? LEVEL_MAX : v[LVL_W-1:0];
  endfunction : clip
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      unit_q <= 2'h0;
      cust_q <= 1'b0;
      fhi_q <= HIFLOW_DEF;
      flo_q <= LOFLOW_DEF;
      thi_q <= RTDH_DEF;
      tlo_q <= RTDL_DEF;
    end else if (ce_in && wr_in) begin
      if (addr_in == A_CTRL) begin
        unit_q <= wdata_in[1:0];
        cust_q <= wdata_in[CTRL_CUSTOM_BIT];
      end
      if (addr_in == A_FLOW) begin
        fhi_q <= clip(wdata_in[15:0]);
        flo_q <= clip(wdata_in[31:16]);
      end
      if (addr_in == A_RTD) begin
        thi_q <= clip(wdata_in[15:0]);
        tlo_q <= clip(wdata_in[31:16]);
      end
    end
  end
  assign conv = (unit_q == 2'h1) ? CONV_W'(flow_lps_in) * 28'd60 :
                (unit_q == 2'h2) ? CONV_W'(flow_lps_in) * 28'd3600 : CONV_W'(flow_lps_in);
  assign en0 = timer_in_in[0].logic_input_one & timer_in_in[0].logic_input_two & !timer_in_in[0].logic_input_three;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  high_flow_flag_a: assert property ($past(rst_n_in) |->
    sources_out.high_flow_flag == ($past(conv) > $past(fhi_q)))
    else $error("high flow flag wrong");
  low_flow_flag_a: assert property ($past(rst_n_in) |->
    sources_out.low_flow_flag == ($past(conv) < $past(flo_q)))
    else $error("low flow flag wrong");
  rtd_high_a: assert property ($past(rst_n_in) |->
    sources_out.rtd_one_high_flag == ($past(rtd_temp_in) > $past(thi_q)))
    else $error("rtd high flag wrong");
  rtd_low_a: assert property ($past(rst_n_in) |->
    sources_out.rtd_one_low_flag == ($past(rtd_temp_in) < $past(tlo_q)))
    else $error("rtd low flag wrong");
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data outside read answer");
  status_read_a: assert property ($past(rd_in) && $past(addr_in) == A_STAT |->
    rdata_out[7:0] == $past(sources_out))
    else $error("status read differs from sources");
  unmapped_read_a: assert property ($past(rd_in) && $past(addr_in) == 8'hfc |-> rdata_out == '0)
    else $error("unmapped read not zero");
  timer_reset_a: assert property ((!cust_q && timer_in_in[0].logic_input_three)[*3] |=>
    !sources_out.timer_out[0])
    else $error("timer output high under reset");
  timer_rise_a: assert property (!cust_q && $rose(sources_out.timer_out[0]) |->
    $past(en0, 2) || $past(en0, 3) || $past(en0, 4))
    else $error("timer output rose without enable");
endmodule : dtl_chk
bind dtl_timer_compare dtl_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .flow_lps_in(flow_lps_in), .rtd_temp_in(rtd_temp_in), .litre_pulse_in(litre_pulse_in),
  .timer_in_in(timer_in_in), .sources_out(sources_out));

// ---- test/testbench.sv ----
// testbench: self-checking run of the timer and level compare block
`timescale 1ns/1ns
module testbench;
  import dtl_pkg::*;
  localparam int unsigned TICKS = 10;
  localparam logic [AW-1:0] A_CFG1 = A_TMR0 + TMR_STRIDE;
  localparam logic [AW-1:0] A_CFG2 = A_CFG1 + TMR_STRIDE;
  logic ref_clk_in = 1'b0;
  logic rst_n_in;
  logic ce_in;
  logic [AW-1:0] addr_in;
  logic [DW-1:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [DW-1:0] rdata_out;
  logic [FLOW_W-1:0] flow_lps_in;
  logic [TEMP_W-1:0] rtd_temp_in;
  logic litre_pulse_in;
  dtl_tin_s [NTMR-1:0] timer_in_in;
  dtl_src_s sources_out;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int hi, lo, u, f, n;
  int vq[$];
  logic [DW-1:0] rv;
  dtl_timer_compare #(.TICK_CYCLES(TICKS)) DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .flow_lps_in(flow_lps_in), .rtd_temp_in(rtd_temp_in), .litre_pulse_in(litre_pulse_in),
    .timer_in_in(timer_in_in), .sources_out(sources_out));
  initial begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  function automatic int mul(input int x);
    return (x == 1) ? 60 : (x == 2) ? 3600 : 1;
  endfunction : mul
  function automatic int clp(input int v);
    return (v > 2000) ? 2000 : v;
  endfunction : clp
  function automatic logic [DW-1:0] ev(input int d, input int onh, input int onm, input int offh, input int offm);
    return (d << 22) | (offh << 17) | (offm << 11) | (onh << 6) | onm;
  endfunction : ev
  task automatic cw(input int k);
    repeat (k) @(posedge ref_clk_in);
  endtask : cw
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // read answer stands only in the cycle after the strobe; it is taken at the edge closing that cycle,
  // before the design clears it, so every later drive still lands on a rising edge
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] exp);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(posedge ref_clk_in);
    chk(rdata_out & m, exp);
  endtask : rchk
  task automatic done(input string s);
    $display("test %s finished: %0d compares, %0d mismatches", s, cmp_count, fail_count);
  endtask : done
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    addr_in = '0;
    wdata_in = '0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    flow_lps_in = '0;
    rtd_temp_in = '0;
    litre_pulse_in = 1'b0;
    timer_in_in = '0;
    rv = $urandom(32'h6bdd3809);
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    vq = '{A_CTRL, 0, A_FLOW, {5'h0, LOFLOW_DEF, 5'h0, HIFLOW_DEF}, A_RTD, {5'h0, RTDL_DEF, 5'h0, RTDH_DEF},
           A_TMR0, TCFG_DEF, A_TMR0 + TAB_OFS, TTAB_DEF, A_VOL, 0, A_EVT0, 0, 8'hfc, 0};
    for (int i = 0; i < vq.size(); i += 2) rchk(AW'(vq[i]), '1, vq[i + 1]);
    done("reset values");
    for (int i = 0; i < 9; i++) begin
      u = i % 3;
      hi = $urandom_range(2047);
      lo = $urandom_range(2047);
      wr(A_CTRL, u);
      wr(A_FLOW, (lo << 16) | hi);
      hi = clp(hi);
      lo = clp(lo);
      rchk(A_FLOW, '1, (lo << 16) | hi);
      f = (i == 3) ? hi : (i == 6) ? lo : $urandom_range(2100) / mul(u);
      flow_lps_in <= FLOW_W'(f);
      cw(3);
      rchk(A_STAT, 32'h18, {f * mul(u) < lo, f * mul(u) > hi, 3'h0});
      rchk(A_FDISP, '1, f * mul(u));
    end
    done("flow");
    for (int i = 0; i < 6; i++) begin
      hi = $urandom_range(2047);
      lo = $urandom_range(2047);
      wr(A_RTD, (lo << 16) | hi);
      hi = clp(hi);
      lo = clp(lo);
      f = (i == 2) ? hi : $urandom_range(2100);
      rtd_temp_in <= TEMP_W'(f);
      cw(3);
      rchk(A_STAT, 32'h60, {f < lo, f > hi, 5'h0});
    end
    done("rtd");
    n = $urandom_range(9, 3);
    repeat (n) begin
      @(posedge ref_clk_in);
      litre_pulse_in <= 1'b1;
      @(posedge ref_clk_in);
      litre_pulse_in <= 1'b0;
    end
    rchk(A_VOL, '1, n);
    wr(A_CTRL, 32'h0);
    rchk(A_VOL, '1, n);
    wr(A_CTRL, 32'h8);
    rchk(A_VOL, '1, 0);
    // a pulse while the clock enable is low must not count
    ce_in <= 1'b0;
    litre_pulse_in <= 1'b1;
    cw(1);
    ce_in <= 1'b1;
    litre_pulse_in <= 1'b0;
    rchk(A_VOL, '1, 0);
    done("volume");
    wr(A_TMR0, 32'h3);
    timer_in_in[0] <= 3'b110;
    cw(5);
    rchk(A_STAT, 32'h1, 0);
    cw(50);
    rchk(A_STAT, 32'h1, 32'h1);
    timer_in_in[0] <= 3'b111;
    cw(4);
    rchk(A_STAT, 32'h1, 0);
    rchk(A_TEL0, '1, 0);
    timer_in_in[0] <= 3'b000;
    wr(A_CFG1, 32'h0004_0002);
    timer_in_in[1] <= 3'b110;
    cw(5);
    rchk(A_STAT, 32'h2, 32'h2);
    timer_in_in[1] <= 3'b010;
    cw(3);
    rchk(A_STAT, 32'h2, 32'h2);
    cw(40);
    rchk(A_STAT, 32'h2, 0);
    done("timers");
    wr(A_CFG2, 32'h0);
    wr(A_CTRL, 32'h4);
    for (int t = 0; t < 8; t++) begin
      wr(A_CFG2 + TAB_OFS, 32'h1 << t);
      timer_in_in[2] <= 3'(t);
      cw(5);
      rchk(A_STAT, 32'h4, 32'h4);
      timer_in_in[2] <= 3'(t ^ 7);
      cw(5);
      rchk(A_STAT, 32'h4, 0);
    end
    done("custom logic");
    wr(A_CTRL, 32'h0);
    wr(A_TOD, (2 << 17) | (10 << 12));
    for (int e = 0; e < 4; e++) begin
      wr(AW'(A_EVT0 + 4 * e), ev(4, 10, 0, 10, 1));
      cw(3);
      rchk(A_STAT, 32'h80, 32'h80);
      wr(AW'(A_EVT0 + 4 * e), ev(8, 10, 0, 10, 1));
      cw(3);
      rchk(A_STAT, 32'h80, 0);
    end
    // on time after off time means the window spans midnight
    wr(A_EVT0, ev(4, 23, 0, 10, 1));
    cw(3);
    rchk(A_STAT, 32'h80, 32'h80);
    wr(A_TOD, (2 << 17) | (10 << 12) | (1 << 6));
    cw(3);
    rchk(A_STAT, 32'h80, 0);
    done("schedule");
    // second reset in mid-run; the preload only happens if no enable edge came since reset,
    // so the enable rises in the very cycle the init mode becomes visible
    rst_n_in <= 1'b0;
    timer_in_in <= '0;
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rchk(A_FLOW, '1, {5'h0, LOFLOW_DEF, 5'h0, HIFLOW_DEF});
    wr(A_TMR0, 32'h0002_0005);
    timer_in_in[0] <= 3'b110;
    cw(3);
    rchk(A_STAT, 32'h1, 32'h1);
    rchk(A_TEL0, '1, 5);
    done("preload");
    report_and_stop();
  end
endmodule : testbench
